// file: src/pfc_map.vh
/*
  Holds the offsets, field positions and bus transfer encodings for the
  port flow control register block.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef PFC_MAP_VH
`define PFC_MAP_VH

`define PFC_FLOW_CTRL_OFFSET   12'h1A4
`define PFC_ADDR_WIDTH         12
`define PFC_BIT_BP_EN          6
`define PFC_BIT_DUPLEX         5
`define PFC_BIT_RX_ACTIVE      4
`define PFC_BIT_TX_ACTIVE      3
`define PFC_BIT_RX_EN          2
`define PFC_BIT_TX_EN          1
`define PFC_BIT_OVERRIDE       0
`define PFC_RW_MASK            32'h00000047
`define PFC_HTRANS_NONSEQ      2'h2
`define PFC_HTRANS_SEQ         2'h3
`define PFC_HSIZE_WORD         3'h2

`endif

// file: src/pfc_status_reg.v
/*
  Holds the registered status bits: current duplex and the pause settings
  in effect, resolved from the control bits and the negotiation inputs.
  Assumes the control bits come from flops in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.vh"

module pfc_status_reg (
  input  wire mclk,
  input  wire rst,
  input  wire strap_duplex_half,
  input  wire strap_rx_active,
  input  wire strap_tx_active,
  input  wire link_half_duplex,
  input  wire autoneg_enable,
  input  wire autoneg_rx_pause,
  input  wire autoneg_tx_pause,
  input  wire rx_pause_enable,
  input  wire tx_pause_enable,
  input  wire pause_override_select,
  output reg  duplex_status_q,
  output reg  rx_pause_active_q,
  output reg  tx_pause_active_q
);

  reg rx_d;
  reg tx_d;

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    if (link_half_duplex) begin
      // pause frames are meaningless in half duplex
      rx_d = 1'b0;
      tx_d = 1'b0;
    end else if (pause_override_select) begin
      rx_d = rx_pause_enable;
      tx_d = tx_pause_enable;
    end else if (autoneg_enable) begin
      rx_d = autoneg_rx_pause;
      tx_d = autoneg_tx_pause;
    end else begin
      rx_d = rx_pause_enable;
      tx_d = tx_pause_enable;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      duplex_status_q   <= strap_duplex_half;
      rx_pause_active_q <= strap_rx_active;
      tx_pause_active_q <= strap_tx_active;
    end else begin
      duplex_status_q   <= link_half_duplex;
      rx_pause_active_q <= rx_d;
      tx_pause_active_q <= tx_d;
    end
  end

endmodule // pfc_status_reg

`default_nettype wire

// file: src/pfc_port_flow_ctrl.v
/*
  Holds the port flow control register behind an AHB-Lite slave, with the
  control bits driven out to the port's MAC and the status read back.
  Assumes synchronous straps during reset, single-word transfers and
  negotiation results already in the mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.vh"

module pfc_port_flow_ctrl #(
  parameter AW = `PFC_ADDR_WIDTH
) (
  input  wire          mclk,
  input  wire          rst,
  input  wire          hsel,
  input  wire [AW-1:0] haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output reg  [31:0]   hrdata,
  output reg           hreadyout,
  output reg           hresp,
  input  wire          backpressure_default_strap,
  input  wire          fd_pause_default_strap,
  input  wire          pause_override_default_strap,
  input  wire          duplex_default_strap,
  input  wire          autoneg_default_strap,
  input  wire          link_half_duplex,
  input  wire          autoneg_enable,
  input  wire          autoneg_rx_pause,
  input  wire          autoneg_tx_pause,
  output reg           backpressure_enable,
  output reg           rx_pause_enable,
  output reg           tx_pause_enable,
  output reg           pause_override_select,
  output reg           rx_pause_active,
  output reg           tx_pause_active,
  output reg           duplex_status
);

  reg  wr_pend_q;
  reg  rd_pend_q;
  reg  hit_q;
  wire duplex_q;
  wire rx_act_q;
  wire tx_act_q;
  wire addr_hit;
  wire take;
  wire strap_rx;
  wire strap_tx;
  reg  [31:0] rd_d;

  function word_ok;
    input [2:0] sz;
    begin
      word_ok = (sz == `PFC_HSIZE_WORD);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // address phase capture
  assign take     = hsel & hready & htrans[1];
  assign addr_hit = (haddr == `PFC_FLOW_CTRL_OFFSET) & word_ok(hsize);

  // reset-time pause status: straps imply full duplex with forced pause
  // only when not negotiating or overridden
  assign strap_rx = ~duplex_default_strap & fd_pause_default_strap &
                    (pause_override_default_strap | ~autoneg_default_strap);
  assign strap_tx = strap_rx;

  always @* begin
    rd_d = 32'h00000000;
    if (hit_q) begin
      rd_d[`PFC_BIT_BP_EN]     = backpressure_enable;
      rd_d[`PFC_BIT_DUPLEX]    = duplex_q;
      rd_d[`PFC_BIT_RX_ACTIVE] = rx_act_q;
      rd_d[`PFC_BIT_TX_ACTIVE] = tx_act_q;
      rd_d[`PFC_BIT_RX_EN]     = rx_pause_enable;
      rd_d[`PFC_BIT_TX_EN]     = tx_pause_enable;
      rd_d[`PFC_BIT_OVERRIDE]  = pause_override_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hit_q     <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else begin
      hresp <= 1'b0;
      if (hready) begin
        wr_pend_q <= take & hwrite;
        rd_pend_q <= take & ~hwrite;
        hit_q     <= take & addr_hit;
        // reads stall once so hrdata stands in a flop
        hreadyout <= ~(take & ~hwrite);
      end else begin
        rd_pend_q <= 1'b0;
        hreadyout <= 1'b1;
        if (rd_pend_q)
          hrdata <= rd_d;
      end
    end
  end

  // the wait cycle also lets a read right after a write see the new bits
  always @(posedge mclk) begin
    if (rst) begin
      backpressure_enable   <= backpressure_default_strap;
      rx_pause_enable       <= fd_pause_default_strap;
      tx_pause_enable       <= fd_pause_default_strap;
      pause_override_select <= pause_override_default_strap;
    end else if (wr_pend_q & hit_q & hready) begin
      // only writable bits move; status and reserved bits drop
      backpressure_enable   <= hwdata[`PFC_BIT_BP_EN];
      rx_pause_enable       <= hwdata[`PFC_BIT_RX_EN];
      tx_pause_enable       <= hwdata[`PFC_BIT_TX_EN];
      pause_override_select <= hwdata[`PFC_BIT_OVERRIDE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  pfc_status_reg u_status (
    .mclk                  (mclk),
    .rst                   (rst),
    .strap_duplex_half     (duplex_default_strap),
    .strap_rx_active       (strap_rx),
    .strap_tx_active       (strap_tx),
    .link_half_duplex      (link_half_duplex),
    .autoneg_enable        (autoneg_enable),
    .autoneg_rx_pause      (autoneg_rx_pause),
    .autoneg_tx_pause      (autoneg_tx_pause),
    .rx_pause_enable       (rx_pause_enable),
    .tx_pause_enable       (tx_pause_enable),
    .pause_override_select (pause_override_select),
    .duplex_status_q       (duplex_q),
    .rx_pause_active_q     (rx_act_q),
    .tx_pause_active_q     (tx_act_q)
  );

  always @(posedge mclk) begin
    if (rst) begin
      duplex_status   <= duplex_default_strap;
      rx_pause_active <= strap_rx;
      tx_pause_active <= strap_tx;
    end else begin
      duplex_status   <= duplex_q;
      rx_pause_active <= rx_act_q;
      tx_pause_active <= tx_act_q;
    end
  end

endmodule // pfc_port_flow_ctrl

`default_nettype wire

// file: bench/pfc_checker.sv
/* port flow control checker: write, status and strap relations
   assumes: bound into pfc_port_flow_ctrl, one clock, sync reset */
`timescale 1ns/1ps
`default_nettype none
module pfc_checker #(parameter AW = 12) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic backpressure_default_strap,
  input wire logic fd_pause_default_strap,
  input wire logic pause_override_default_strap,
  input wire logic duplex_default_strap,
  input wire logic autoneg_default_strap,
  input wire logic link_half_duplex,
  input wire logic autoneg_enable,
  input wire logic autoneg_rx_pause,
  input wire logic autoneg_tx_pause,
  input wire logic backpressure_enable,
  input wire logic rx_pause_enable,
  input wire logic tx_pause_enable,
  input wire logic pause_override_select,
  input wire logic rx_pause_active,
  input wire logic tx_pause_active,
  input wire logic duplex_status
);
  ////////////////////////////////////////////////////////////////
  logic wr_q;
  logic [6:0] v_q;
  logic [1:0] st_q;
  wire [6:0] v_d = {link_half_duplex, autoneg_enable, autoneg_rx_pause, autoneg_tx_pause,
    rx_pause_enable, tx_pause_enable, pause_override_select};
  wire sel = pause_override_select | ~autoneg_enable;
  // a cause that moves in this very cycle is not yet visible at the outputs
  wire quiet = st_q == 2'h3 && v_d == v_q;
  wire strap_act = ~duplex_default_strap & fd_pause_default_strap &
    (pause_override_default_strap | ~autoneg_default_strap);
  // status sits two flops behind its causes, so wait for three quiet cycles
  always_ff @(posedge mclk) begin
    wr_q <= !rst && hready && hsel && htrans[1] && hwrite && haddr == 12'h1A4 && hsize == 3'h2;
    v_q <= v_d;
    st_q <= (rst || v_d != v_q) ? 2'h0 : (st_q == 2'h3 ? st_q : st_q + 2'h1);
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_BP_WR: assert property (wr_q |=> backpressure_enable == $past(hwdata[6])) else $error("bp write");
  AST_RX_WR: assert property (wr_q |=> rx_pause_enable == $past(hwdata[2])) else $error("rx write");
  AST_TX_WR: assert property (wr_q |=> tx_pause_enable == $past(hwdata[1])) else $error("tx write");
  AST_OV_WR: assert property (wr_q |=> pause_override_select == $past(hwdata[0])) else $error("ov write");
  AST_DUP: assert property (quiet |-> duplex_status == link_half_duplex) else $error("duplex");
  AST_RX_ACT: assert property (quiet |-> rx_pause_active ==
    (~link_half_duplex & (sel ? rx_pause_enable : autoneg_rx_pause))) else $error("rx active");
  AST_TX_ACT: assert property (quiet |-> tx_pause_active ==
    (~link_half_duplex & (sel ? tx_pause_enable : autoneg_tx_pause))) else $error("tx active");
  AST_STRAP_BP: assert property (disable iff (1'b0) rst |=> backpressure_enable ==
    $past(backpressure_default_strap) && pause_override_select == $past(pause_override_default_strap))
    else $error("bp strap");
  AST_STRAP_FD: assert property (disable iff (1'b0) rst |=> rx_pause_enable ==
    $past(fd_pause_default_strap) && tx_pause_enable == $past(fd_pause_default_strap)) else $error("fd strap");
  AST_STAT_RST: assert property (disable iff (1'b0) rst |=> duplex_status == $past(duplex_default_strap) &&
    rx_pause_active == $past(strap_act) && tx_pause_active == $past(strap_act)) else $error("status strap");
  AST_RSVD: assert property (hrdata[31:7] == 25'h0) else $error("reserved bits");
endmodule // pfc_checker
bind pfc_port_flow_ctrl pfc_checker #(.AW(AW)) u_chk (.*);
`default_nettype wire

// file: bench/pfc_port_flow_ctrl_tb.sv
/* port flow control bench: strap resets, writes, reads and misses
   assumes: design and checker compiled first, reads stall once */
`timescale 1ns/1ps
`default_nettype none
module pfc_port_flow_ctrl_tb;
  `define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
  logic mclk, rst, hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r, d, e;
  logic backpressure_default_strap, fd_pause_default_strap, pause_override_default_strap, duplex_default_strap;
  logic autoneg_default_strap, link_half_duplex, autoneg_enable, autoneg_rx_pause, autoneg_tx_pause;
  logic backpressure_enable, rx_pause_enable, tx_pause_enable, pause_override_select;
  logic rx_pause_active, tx_pause_active, duplex_status;
  logic [6:0] ctl;
  int n_fail, n_tests;
  wire hready = hreadyout;
  pfc_port_flow_ctrl #(.AW(12)) dut (.*);
  always #2 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // read data taken at the edge that ends the data phase, whatever the wait
  task automatic xfer(input [11:0] a, input w, input [2:0] sz, input [31:0] wd);
    int i;
    {hsel, haddr, htrans, hwrite, hsize} <= {1'b1, a, 2'h2, w, sz};
    for (int p = 0; p < 2; p++) begin
      i = 0;
      do @(posedge mclk); while (hready !== 1'b1 && ++i < 64);
      if (i >= 64) begin
        n_fail++;
        final_report();
      end
      if (p == 0) {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    end
    r = hrdata;
  endtask
  function automatic logic [31:0] model();
    logic s;
    s = ctl[0] | ~autoneg_enable;
    return {25'h0, ctl[6], link_half_duplex, ~link_half_duplex & (s ? ctl[2] : autoneg_rx_pause),
      ~link_half_duplex & (s ? ctl[1] : autoneg_tx_pause), ctl[2:0]};
  endfunction
  initial begin
    {mclk, hsel, hwrite, haddr, htrans, hsize, hwdata, n_fail, n_tests} = '0;
    {link_half_duplex, autoneg_enable, autoneg_rx_pause, autoneg_tx_pause} = '0;
    void'($urandom(76338));
    repeat (2) begin
      {backpressure_default_strap, fd_pause_default_strap, pause_override_default_strap, duplex_default_strap,
        autoneg_default_strap} <= 5'($urandom);
      rst <= 1'b1;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      ctl = {backpressure_default_strap, 3'h0, fd_pause_default_strap, fd_pause_default_strap,
        pause_override_default_strap};
      @(posedge mclk);
      `CHK({backpressure_enable, rx_pause_enable, tx_pause_enable, pause_override_select}, {ctl[6], ctl[2:0]})
      e = {29'h0, duplex_default_strap, {2{~duplex_default_strap & fd_pause_default_strap &
        (pause_override_default_strap | ~autoneg_default_strap)}}};
      `CHK({duplex_status, rx_pause_active, tx_pause_active}, e[2:0])
      for (int n = 0; n < 24; n++) begin
        {link_half_duplex, autoneg_enable, autoneg_rx_pause, autoneg_tx_pause} <= 4'($urandom);
        d = $urandom;
        // the third and fourth write of every group of four miss on address or size and must leave the word alone
        xfer(n % 4 == 2 ? 12'h1A8 : 12'h1A4, 1'b1, n % 4 == 3 ? 3'h1 : 3'h2, d);
        if (n % 4 < 2) ctl = d[6:0] & 7'h47;
        xfer(12'h1A4, 1'b0, 3'h2, 32'h0);
        e = model();
        `CHK(r, e)
        r = {25'h0, backpressure_enable, duplex_status, rx_pause_active, tx_pause_active, rx_pause_enable,
          tx_pause_enable, pause_override_select};
        `CHK(r, e)
        xfer(12'h1A8, 1'b0, 3'h2, 32'h0);
        `CHK(r, 32'h0)
      end
    end
    `CHK(hresp, 1'b0)
    final_report();
  end
endmodule // pfc_port_flow_ctrl_tb
`default_nettype wire
